/* File: core/htc_map.vh */
// register layout and encodings for the hypervisor trap decision block
`ifndef HTC_MAP_VH
`define HTC_MAP_VH
// ****************************************
// hyp_trap_config field positions
// ****************************************
`define HTC_BIT_STAGE2_ENABLE   0
`define HTC_BIT_DEFAULT_CACHE   12
`define HTC_BIT_TRAP_WFI        13
`define HTC_BIT_TRAP_WFE        14
`define HTC_BIT_TRAP_ID0        15
`define HTC_BIT_TRAP_ID1        16
`define HTC_BIT_TRAP_ID2        17
`define HTC_BIT_TRAP_ID3        18
`define HTC_BIT_TRAP_IMPDEF     20
`define HTC_BIT_TRAP_AUX        21
`define HTC_BIT_TRAP_SETWAY     22
`define HTC_BIT_TRAP_POC        23
// fields this block holds: 23:20, 18:12 and 0
`define HTC_IMPL_MASK           32'h00F7_F001
`define HTC_RESET_VALUE         32'h0000_0000
// ****************************************
// operation class codes from the pipeline
// ****************************************
`define HTC_OP_NONE             4'h0
`define HTC_OP_SYSREG           4'h1
`define HTC_OP_DC_POC           4'h2
`define HTC_OP_DC_SETWAY        4'h3
`define HTC_OP_WFE              4'h4
`define HTC_OP_WFI              4'h5
// exception level encodings
`define HTC_EL0                 2'h0
`define HTC_EL1                 2'h1
`define HTC_EL2                 2'h2
// ****************************************
// system register group codes from the decoder
// ****************************************
`define HTC_GRP_OTHER           4'h0
`define HTC_GRP_AUX_CTRL        4'h1
`define HTC_GRP_BYTECODE_ID     4'h2
`define HTC_GRP_FLOAT_ID        4'h3
`define HTC_GRP_CACHE_TYPE      4'h4
`define HTC_GRP_CACHE_SIZE      4'h5
`define HTC_GRP_CACHE_LEVEL     4'h6
`define HTC_GRP_CACHE_SELECT    4'h7
`define HTC_GRP_ID_ONE          4'h8
// outcome codes
`define HTC_OUT_NONE            2'h0
`define HTC_OUT_HYP_TRAP        2'h1
`define HTC_OUT_UNDEF           2'h2
// default memory attribute: normal, inner/outer wb ra wa
`define HTC_ATTR_NORMAL_WB      8'hFF
`endif

/* File: core/htc_cp15_decode.v */
// encoding classifier for coprocessor-15 trap groups keyed by CRn/CRm/opc1/opc2
`timescale 1ns/100ps
module htc_cp15_decode (
  input  wire [3:0] crn_in,
  input  wire [3:0] crm_in,
  input  wire [2:0] opc1_in,
  input  wire [2:0] opc2_in,
  input  wire       opt_id3_in,
  output reg        impdef_out,
  output reg        id3_out
);
  always @* begin
    impdef_out = 1'b0;
    case (crn_in)
      4'h9:    impdef_out = (crm_in <= 4'h2) || (crm_in >= 4'h5 && crm_in <= 4'h8);
      4'hA:    impdef_out = (crm_in == 4'h0) || (crm_in == 4'h1) || (crm_in == 4'h4) || (crm_in == 4'h8);
      4'hB:    impdef_out = (crm_in <= 4'h8) || (crm_in == 4'hF);
      default: impdef_out = 1'b0;
    endcase
    id3_out = 1'b0;
    if (crn_in == 4'h0 && opc1_in == 3'h0) begin
      if (crm_in >= 4'h3 && crm_in <= 4'h7 && opc2_in <= 3'h1)
        id3_out = 1'b1;
      else if (crm_in == 4'h3 && opc2_in == 3'h2)
        id3_out = 1'b1;
      else if (crm_in == 4'h5 && (opc2_in == 3'h4 || opc2_in == 3'h5))
        id3_out = 1'b1;
      else if (opt_id3_in) begin
        // optional spare encodings, includes the zero-reading fourth memory feature slot
        if (crm_in == 4'h2 && opc2_in == 3'h7)
          id3_out = 1'b1;
        else if (crm_in == 4'h3 && opc2_in >= 3'h3)
          id3_out = 1'b1;
        else if ((crm_in == 4'h4 || crm_in == 4'h6 || crm_in == 4'h7) && opc2_in >= 3'h2)
          id3_out = 1'b1;
        else if (crm_in == 4'h5 && opc2_in != 3'h4 && opc2_in != 3'h5 && opc2_in >= 3'h2)
          id3_out = 1'b1;
      end
    end
  end
endmodule

/* File: core/htc_trap_decode.v */
// hypervisor trap decision and default-cacheability override driven by hyp_trap_config
`timescale 1ns/100ps
`include "htc_map.vh"
module htc_trap_decode #(
  parameter POC_TRAPPABLE    = 1,
  parameter EL0_IMPDEF_TRAP  = 0,
  parameter OPT_ID3_TRAP     = 1,
  parameter BYTECODE_EL0_RAZ = 1
) (
  input  wire        clk_in,
  input  wire        rst_in,
  // register port from the system register path
  input  wire        cfg_wr_in,
  input  wire [31:0] cfg_wdata_in,
  output wire [31:0] cfg_rdata_out,
  // operation offered by the pipeline before commit
  input  wire        op_valid_in,
  input  wire [3:0]  op_class_in,
  input  wire [1:0]  op_el_in,
  input  wire        op_write_in,
  input  wire [3:0]  op_group_in,
  input  wire        op_cp15_in,
  input  wire [3:0]  op_crn_in,
  input  wire [3:0]  op_crm_in,
  input  wire [2:0]  op_opc1_in,
  input  wire [2:0]  op_opc2_in,
  input  wire        op_cond_pass_in,
  input  wire        op_would_block_in,
  input  wire        user_wait_event_permit_in,
  input  wire        user_wait_interrupt_permit_in,
  // decision
  output reg  [1:0]  op_outcome_out,
  output wire        op_commit_ok_out,
  output wire        op_hyp_trap_out,
  output wire        op_undef_out,
  // translation regime controls
  output wire        stage2_enable_eff_out,
  output wire        default_map_override_out,
  output wire [7:0]  default_mem_attr_out,
  output wire        default_exec_ok_out
);
  // ****************************************
  // configuration register
  // ****************************************
  reg  [31:0] hyp_trap_config_r;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hyp_trap_config_r <= `HTC_RESET_VALUE;
    end else if (cfg_wr_in) begin
      hyp_trap_config_r <= cfg_wdata_in & `HTC_IMPL_MASK;
    end
  end
  // direct read returns stored stage 2 enable, unforced
  assign cfg_rdata_out = hyp_trap_config_r;

  wire trap_coherency_point_maint = hyp_trap_config_r[`HTC_BIT_TRAP_POC];
  wire trap_setway_maint          = hyp_trap_config_r[`HTC_BIT_TRAP_SETWAY];
  wire trap_aux_control_access    = hyp_trap_config_r[`HTC_BIT_TRAP_AUX];
  wire trap_impl_defined_sysregs  = hyp_trap_config_r[`HTC_BIT_TRAP_IMPDEF];
  wire trap_id_group_three        = hyp_trap_config_r[`HTC_BIT_TRAP_ID3];
  wire trap_id_group_two          = hyp_trap_config_r[`HTC_BIT_TRAP_ID2];
  wire trap_id_group_one          = hyp_trap_config_r[`HTC_BIT_TRAP_ID1];
  wire trap_id_group_zero         = hyp_trap_config_r[`HTC_BIT_TRAP_ID0];
  wire trap_wait_event            = hyp_trap_config_r[`HTC_BIT_TRAP_WFE];
  wire trap_wait_interrupt        = hyp_trap_config_r[`HTC_BIT_TRAP_WFI];
  wire default_cacheable          = hyp_trap_config_r[`HTC_BIT_DEFAULT_CACHE];
  wire stage2_enable              = hyp_trap_config_r[`HTC_BIT_STAGE2_ENABLE];

  // ****************************************
  // encoding classification
  // ****************************************
  wire enc_impdef;
  wire enc_id3;
  htc_cp15_decode u_cp15 (
    .crn_in     (op_crn_in),
    .crm_in     (op_crm_in),
    .opc1_in    (op_opc1_in),
    .opc2_in    (op_opc2_in),
    .opt_id3_in (OPT_ID3_TRAP != 0),
    .impdef_out (enc_impdef),
    .id3_out    (enc_id3)
  );

  wire at_el0   = (op_el_in == `HTC_EL0);
  wire at_el1   = (op_el_in == `HTC_EL1);
  wire guest_el = at_el0 | at_el1;
  wire is_read  = ~op_write_in;
  wire sysreg   = (op_class_in == `HTC_OP_SYSREG);
  wire cp15     = sysreg & op_cp15_in;
  wire grp_cache_id = (op_group_in == `HTC_GRP_CACHE_TYPE) | (op_group_in == `HTC_GRP_CACHE_SIZE) |
                      (op_group_in == `HTC_GRP_CACHE_LEVEL) | (op_group_in == `HTC_GRP_CACHE_SELECT);

  // ****************************************
  // trap decision, purely combinational so it is ready before commit
  // ****************************************
  reg hyp_trap;
  reg undef;
  always @* begin
    hyp_trap = 1'b0;
    undef    = 1'b0;
    case (op_class_in)
      `HTC_OP_DC_POC: begin
        if (at_el0)
          undef = 1'b1;
        else if (at_el1 && trap_coherency_point_maint && POC_TRAPPABLE != 0)
          hyp_trap = 1'b1;
      end
      `HTC_OP_DC_SETWAY: begin
        if (at_el0)
          undef = 1'b1;
        else if (at_el1 && trap_setway_maint)
          hyp_trap = 1'b1;
      end
      `HTC_OP_WFE: begin
        // failing condition or non-blocking wait never traps
        if (guest_el && op_cond_pass_in && op_would_block_in) begin
          if (at_el0 && !user_wait_event_permit_in)
            undef = 1'b1;
          else if (trap_wait_event)
            hyp_trap = 1'b1;
        end
      end
      `HTC_OP_WFI: begin
        if (guest_el && op_cond_pass_in && op_would_block_in) begin
          if (at_el0 && !user_wait_interrupt_permit_in)
            undef = 1'b1;
          else if (trap_wait_interrupt)
            hyp_trap = 1'b1;
        end
      end
      `HTC_OP_SYSREG: begin
        if (at_el1 && trap_aux_control_access && op_group_in == `HTC_GRP_AUX_CTRL)
          hyp_trap = 1'b1;
        if (cp15 && enc_impdef && trap_impl_defined_sysregs) begin
          if (at_el1)
            hyp_trap = 1'b1;
          else if (at_el0 && EL0_IMPDEF_TRAP != 0)
            hyp_trap = 1'b1;
          else if (at_el0)
            undef = 1'b1;
        end
        if (at_el1 && is_read && cp15 && enc_id3 && trap_id_group_three)
          hyp_trap = 1'b1;
        if (guest_el && trap_id_group_two && grp_cache_id &&
            (is_read || op_group_in == `HTC_GRP_CACHE_SELECT))
          hyp_trap = 1'b1;
        if (at_el1 && is_read && trap_id_group_one && op_group_in == `HTC_GRP_ID_ONE)
          hyp_trap = 1'b1;
        // float ID writes fall through untrapped and are ignored downstream
        if (at_el1 && is_read && trap_id_group_zero &&
            (op_group_in == `HTC_GRP_BYTECODE_ID || op_group_in == `HTC_GRP_FLOAT_ID))
          hyp_trap = 1'b1;
        if (at_el0 && is_read && op_group_in == `HTC_GRP_BYTECODE_ID) begin
          if (BYTECODE_EL0_RAZ == 0)
            undef = 1'b1;
          else if (trap_id_group_zero)
            hyp_trap = 1'b1;
        end
      end
      default: begin
        hyp_trap = 1'b0;
      end
    endcase
    // undefined always outranks the hypervisor trap
    if (undef)
      hyp_trap = 1'b0;
  end

  always @* begin
    if (!op_valid_in)
      op_outcome_out = `HTC_OUT_NONE;
    else if (undef)
      op_outcome_out = `HTC_OUT_UNDEF;
    else if (hyp_trap)
      op_outcome_out = `HTC_OUT_HYP_TRAP;
    else
      op_outcome_out = `HTC_OUT_NONE;
  end
  assign op_hyp_trap_out  = op_valid_in & hyp_trap & ~undef;
  assign op_undef_out     = op_valid_in & undef;
  // commit gate: trapped ops write no state and fire no side effect
  assign op_commit_ok_out = op_valid_in & ~hyp_trap & ~undef;

  // ****************************************
  // translation regime controls (guest regime only)
  // ****************************************
  assign stage2_enable_eff_out    = guest_el & (stage2_enable | default_cacheable);
  assign default_map_override_out = guest_el & default_cacheable;
  assign default_mem_attr_out     = default_map_override_out ? `HTC_ATTR_NORMAL_WB : 8'h00;
  assign default_exec_ok_out      = default_map_override_out;
endmodule

/* File: bench/htc_trap_checker.sv */
// assertion checker for the hypervisor trap decision block
`timescale 1ns/100ps
`include "htc_map.vh"
module htc_trap_checker (
  input wire        clk_in, rst_in, cfg_wr_in, op_valid_in, op_cond_pass_in, op_would_block_in,
  input wire        user_wait_event_permit_in, op_commit_ok_out, op_hyp_trap_out, op_undef_out,
  input wire        stage2_enable_eff_out, default_map_override_out, default_exec_ok_out,
  input wire [31:0] cfg_wdata_in, cfg_rdata_out,
  input wire [3:0]  op_class_in, op_group_in,
  input wire [1:0]  op_el_in, op_outcome_out,
  input wire [7:0]  default_mem_attr_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire at_el1 = op_valid_in && op_el_in == `HTC_EL1;
  wire is_wait = op_class_in == `HTC_OP_WFE || op_class_in == `HTC_OP_WFI;
  wire is_maint = op_class_in == `HTC_OP_DC_POC || op_class_in == `HTC_OP_DC_SETWAY;
  sequence cfg_store;
    cfg_wr_in ##1 cfg_rdata_out == ($past(cfg_wdata_in) & `HTC_IMPL_MASK);
  endsequence
  AST_CFG_STORE: assert property (cfg_wr_in |-> cfg_store) else $error("config store wrong");
  AST_RESET_ZERO: assert property ($fell(rst_in) |-> cfg_rdata_out == 32'h0000_0000)
    else $error("config not cleared");
  AST_POC_TRAP: assert property (at_el1 && op_class_in == `HTC_OP_DC_POC |-> op_hyp_trap_out == cfg_rdata_out[23])
    else $error("coherency trap wrong");
  AST_EL0_MAINT: assert property (op_valid_in && op_el_in == `HTC_EL0 && is_maint |-> op_undef_out && !op_hyp_trap_out)
    else $error("user maintenance not undefined");
  AST_SETWAY_TRAP: assert property (at_el1 && op_class_in == `HTC_OP_DC_SETWAY |-> op_hyp_trap_out == cfg_rdata_out[22])
    else $error("set/way trap wrong");
  AST_AUX_TRAP: assert property (at_el1 && op_class_in == `HTC_OP_SYSREG && op_group_in == `HTC_GRP_AUX_CTRL
    |-> op_hyp_trap_out == cfg_rdata_out[21]) else $error("aux trap wrong");
  AST_WAIT_COND: assert property (op_valid_in && is_wait && !op_cond_pass_in |-> op_outcome_out == `HTC_OUT_NONE)
    else $error("failed condition trapped");
  AST_WFE_USER_UNDEF: assert property (op_valid_in && op_class_in == `HTC_OP_WFE && op_el_in == `HTC_EL0
    && op_cond_pass_in && op_would_block_in && cfg_rdata_out[14] && !user_wait_event_permit_in |-> op_undef_out)
    else $error("user wait not undefined");
  AST_DC_MAP: assert property (op_el_in != `HTC_EL2 && cfg_rdata_out[12] |-> stage2_enable_eff_out
    && default_map_override_out && default_mem_attr_out == `HTC_ATTR_NORMAL_WB && default_exec_ok_out)
    else $error("default map wrong");
  AST_DC_HYP: assert property (op_el_in == `HTC_EL2 |-> !stage2_enable_eff_out && !default_map_override_out)
    else $error("hyp regime touched");
  AST_FLAGS: assert property (op_valid_in |-> op_commit_ok_out == (op_outcome_out == `HTC_OUT_NONE)
    && op_hyp_trap_out == (op_outcome_out == `HTC_OUT_HYP_TRAP)) else $error("flags disagree");
endmodule
bind htc_trap_decode htc_trap_checker chk (.clk_in(clk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr_in),
  .op_valid_in(op_valid_in), .op_cond_pass_in(op_cond_pass_in), .op_would_block_in(op_would_block_in),
  .user_wait_event_permit_in(user_wait_event_permit_in), .op_commit_ok_out(op_commit_ok_out),
  .op_hyp_trap_out(op_hyp_trap_out), .op_undef_out(op_undef_out), .stage2_enable_eff_out(stage2_enable_eff_out),
  .default_map_override_out(default_map_override_out), .default_exec_ok_out(default_exec_ok_out),
  .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out), .op_class_in(op_class_in),
  .op_group_in(op_group_in), .op_el_in(op_el_in), .op_outcome_out(op_outcome_out),
  .default_mem_attr_out(default_mem_attr_out));

/* File: bench/htc_pipe_model.sv */
// pipeline model offering one operation at a time before commit
`timescale 1ns/100ps
module htc_pipe_model (
  input  wire       clk_in,
  output reg        valid_out, write_out, cp15_out, cond_out, block_out, ev_ok_out, int_ok_out,
  output reg  [3:0] class_out, group_out, crn_out, crm_out,
  output reg  [1:0] el_out,
  output reg  [2:0] opc1_out, opc2_out
);
  initial begin
    {valid_out, write_out, cp15_out, cond_out, block_out, class_out, group_out} = 0;
    {crn_out, crm_out, el_out, opc1_out, opc2_out} = 0;
    {ev_ok_out, int_ok_out} = 2'b11;
  end
  // fields move only at the falling edge, well away from the sampling edge
  task issue(input [3:0] c, input [1:0] e, input w, input [3:0] g, n, m, input [2:0] p, q, input cc, bb);
    begin
      @(negedge clk_in);
      {valid_out, class_out, el_out, write_out, group_out, cp15_out} = {1'b1, c, e, w, g, c == 4'h1};
      {crn_out, crm_out, opc1_out, opc2_out, cond_out, block_out} = {n, m, p, q, cc, bb};
      @(posedge clk_in);
      #1;
    end
  endtask
  // user wait permits move only between offers, set at once when called, with no wait for the falling edge
  task permit(input e, input i);
    begin
      ev_ok_out  = e;
      int_ok_out = i;
    end
  endtask
  // a withdrawn offer shows the inverse class, so stale values cannot pass
  task idle;
    begin
      @(negedge clk_in);
      valid_out = 1'b0;
      class_out = ~class_out;
    end
  endtask
endmodule

/* File: bench/testbench.sv */
// self-checking testbench for the hypervisor trap decision block
`timescale 1ns/100ps
`include "htc_map.vh"
module testbench;
  reg         clk_in, rst_in, cfg_wr_in;
  reg  [31:0] cfg_wdata_in;
  wire [31:0] cfg_rdata_out;
  wire        v, w, cp, cd, bk, pe, pi, commit, hyp, undef, s2, ovr, xok;
  wire [3:0]  cls, grp, crn, crm;
  wire [1:0]  el, outc;
  wire [2:0]  o1, o2;
  wire [7:0]  attr;
  integer     miscompares, checks;
  htc_pipe_model pipe (.clk_in(clk_in), .valid_out(v), .write_out(w), .cp15_out(cp), .cond_out(cd),
    .block_out(bk), .ev_ok_out(pe), .int_ok_out(pi), .class_out(cls), .group_out(grp), .crn_out(crn),
    .crm_out(crm), .el_out(el), .opc1_out(o1), .opc2_out(o2));
  htc_trap_decode DUT (.clk_in(clk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr_in), .cfg_wdata_in(cfg_wdata_in),
    .cfg_rdata_out(cfg_rdata_out), .op_valid_in(v), .op_class_in(cls), .op_el_in(el), .op_write_in(w),
    .op_group_in(grp), .op_cp15_in(cp), .op_crn_in(crn), .op_crm_in(crm), .op_opc1_in(o1), .op_opc2_in(o2),
    .op_cond_pass_in(cd), .op_would_block_in(bk), .user_wait_event_permit_in(pe),
    .user_wait_interrupt_permit_in(pi), .op_outcome_out(outc), .op_commit_ok_out(commit),
    .op_hyp_trap_out(hyp), .op_undef_out(undef), .stage2_enable_eff_out(s2),
    .default_map_override_out(ovr), .default_mem_attr_out(attr), .default_exec_ok_out(xok));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
    end
  endtask
  task cfg_write(input [31:0] d);
    begin
      @(negedge clk_in);
      cfg_wr_in = 1'b1;
      cfg_wdata_in = d;
      @(negedge clk_in);
      cfg_wr_in = 1'b0;
    end
  endtask
  // every other control set first, so only bit b can explain a trap
  task row(input [3:0] c, input [1:0] e, input wr, input [3:0] g, n, m, input [2:0] p, q, input cc, bb,
           input integer b, input [1:0] es, ec);
    begin
      cfg_write(`HTC_IMPL_MASK & ~(32'h1 << b));
      pipe.issue(c, e, wr, g, n, m, p, q, cc, bb);
      check(outc, ec);
      check(commit, ec == `HTC_OUT_NONE);
      cfg_write(32'h1 << b);
      pipe.issue(c, e, wr, g, n, m, p, q, cc, bb);
      check(outc, es);
      check({undef, hyp}, es);
      check(commit, es == `HTC_OUT_NONE);
      pipe.idle;
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    miscompares = 0;
    checks = 0;
    rst_in = 1'b1;
    cfg_wr_in = 1'b0;
    cfg_wdata_in = 32'h0000_0000;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    check(cfg_rdata_out, 32'h0000_0000);
    cfg_write(32'hFFFF_FFFF);
    check(cfg_rdata_out, `HTC_IMPL_MASK);
    rst_in = 1'b1;
    @(negedge clk_in);
    rst_in = 1'b0;
    check(cfg_rdata_out, 32'h0000_0000);
    $display("test reset done");
    row(2, 1, 0, 0, 0, 0, 0, 0, 1, 0, 23, 1, 0);
    row(2, 0, 0, 0, 0, 0, 0, 0, 1, 0, 23, 2, 2);
    row(2, 2, 0, 0, 0, 0, 0, 0, 1, 0, 23, 0, 0);
    row(3, 1, 0, 0, 0, 0, 0, 0, 1, 0, 22, 1, 0);
    row(3, 0, 0, 0, 0, 0, 0, 0, 1, 0, 22, 2, 2);
    row(1, 1, 1, 1, 0, 0, 0, 0, 1, 0, 21, 1, 0);
    row(1, 1, 0, 0, 9, 8, 7, 6, 1, 0, 20, 1, 0);
    row(1, 1, 0, 0, 9, 3, 0, 0, 1, 0, 20, 0, 0);
    row(1, 0, 0, 0, 11, 15, 0, 0, 1, 0, 20, 2, 0);
    row(1, 1, 0, 0, 0, 5, 0, 4, 1, 0, 18, 1, 0);
    row(1, 1, 0, 0, 0, 4, 0, 3, 1, 0, 18, 1, 0);
    row(1, 0, 1, 7, 0, 0, 0, 0, 1, 0, 17, 1, 0);
    row(1, 1, 0, 5, 0, 0, 0, 0, 1, 0, 17, 1, 0);
    row(1, 1, 0, 8, 0, 0, 0, 0, 1, 0, 16, 1, 0);
    row(1, 0, 0, 8, 0, 0, 0, 0, 1, 0, 16, 0, 0);
    row(1, 1, 0, 3, 0, 0, 0, 0, 1, 0, 15, 1, 0);
    row(1, 1, 1, 3, 0, 0, 0, 0, 1, 0, 15, 0, 0);
    row(1, 0, 0, 2, 0, 0, 0, 0, 1, 0, 15, 1, 0);
    row(4, 1, 0, 0, 0, 0, 0, 0, 1, 1, 14, 1, 0);
    row(4, 1, 0, 0, 0, 0, 0, 0, 0, 1, 14, 0, 0);
    row(4, 1, 0, 0, 0, 0, 0, 0, 1, 0, 14, 0, 0);
    row(5, 0, 0, 0, 0, 0, 0, 0, 1, 1, 13, 1, 0);
    $display("test trap table done");
    cfg_write(32'h0000_6000);
    pipe.permit(1'b0, 1'b0);
    pipe.issue(4, 0, 0, 0, 0, 0, 0, 0, 1, 1);
    check(outc, `HTC_OUT_UNDEF);
    cfg_write(32'h0000_2000);
    pipe.issue(5, 0, 0, 0, 0, 0, 0, 0, 1, 1);
    check(outc, `HTC_OUT_UNDEF);
    $display("test user wait done");
    cfg_write(32'h0000_1000);
    pipe.issue(0, 1, 0, 0, 0, 0, 0, 0, 1, 0);
    check({s2, ovr, attr, xok}, {2'b11, `HTC_ATTR_NORMAL_WB, 1'b1});
    check(cfg_rdata_out[0], 1'b0);
    pipe.issue(0, 2, 0, 0, 0, 0, 0, 0, 1, 0);
    check({s2, ovr, attr, xok}, 0);
    cfg_write(32'h0000_0001);
    pipe.issue(0, 0, 0, 0, 0, 0, 0, 0, 1, 0);
    check({s2, ovr}, 2'b10);
    $display("test default map done");
    stop_test;
  end
endmodule
